/* File: bench/hdtx_link_model.sv */
`include "hdtx_defs.svh"
`default_nettype none
module hdtx_link_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [1:0] pace,
  input wire logic [2:0] tx_bit,
  output logic [2:0] bit_en,
  output logic byte_vld,
  output logic [7:0] byte_val,
  output logic abort_vld,
  output logic [15:0] n_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] gap_r;
  logic en_d_r, frm_r, b;
  logic [7:0] raw_r, dat_r;
  logic [3:0] nb_r, ones_r;
  assign b = tx_bit[0];
  // only lane 0 is deframed; the others just get bit times
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {gap_r, bit_en, en_d_r, frm_r, raw_r, dat_r, nb_r, ones_r} <= '0;
      {byte_vld, byte_val, abort_vld, n_flag} <= '0;
    end else begin
      byte_vld <= 1'b0;
      abort_vld <= 1'b0;
      bit_en <= (gap_r == 2'h0) ? 3'h7 : 3'h0;
      gap_r <= (gap_r == 2'h0) ? pace : gap_r - 2'h1;
      en_d_r <= bit_en[0];
      if (en_d_r) begin
        raw_r <= {b, raw_r[7:1]};
        ones_r <= b ? ones_r + 4'h1 : 4'h0;
        if ({b, raw_r[7:1]} == `HDTX_FLAG) begin
          frm_r <= 1'b1;
          nb_r <= 4'h0;
          n_flag <= n_flag + 16'h1;
        end else if (b && ones_r == 4'h6) begin
          // one note per abort run, not per character
          abort_vld <= frm_r;
          frm_r <= 1'b0;
        end else if (frm_r && !(ones_r == 4'h5 && !b)) begin
          dat_r <= {b, dat_r[7:1]};
          nb_r <= (nb_r == 4'h7) ? 4'h0 : nb_r + 4'h1;
          if (nb_r == 4'h7) begin
            byte_vld <= 1'b1;
            byte_val <= {b, dat_r[7:1]};
          end
        end
      end
    end
  end
endmodule // hdtx_link_model
`default_nettype wire

/* File: bench/test_hdtx_top.sv */
`include "hdtx_defs.svh"
`default_nettype none
module test_hdtx_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned RPT = 1000;
  logic clk_sys, rst_n, wr_stb, rd_stb, byte_vld, abort_vld, rd_d_r;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, byte_val;
  logic [2:0] bit_en, tx_bit, underrun_flag, fifo_low;
  logic [1:0] pace;
  logic [2:0] h0;
  logic [15:0] n_flag, n0;
  logic [31:0] seed = 32'hed544508;
  logic [7:0] rq[$];
  logic [8:0] bq[$];
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  localparam logic [5:0] RA [9] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h05, 6'h06, 6'h07, 6'h31, 6'h21};
  localparam logic [7:0] RE [9] = '{`HDTX_CFG_RST, `HDTX_UPPER_RST, `HDTX_LOWER_RST, 8'h00,
    8'h00, 8'h00, `HDTX_PERF_RST, 8'h00, `HDTX_UPPER_RST};

  hdtx_top #(.RPT_CYC(RPT)) u_hdtx_top (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .bit_en(bit_en),
    .tx_bit(tx_bit), .underrun_flag(underrun_flag), .fifo_low(fifo_low));
  hdtx_link_model u_hdtx_link_model (.clk_sys(clk_sys), .rst_n(rst_n), .pace(pace),
    .tx_bit(tx_bit), .bit_en(bit_en), .byte_vld(byte_vld), .byte_val(byte_val),
    .abort_vld(abort_vld), .n_flag(n_flag));

  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [15:0] crc_add(input logic [15:0] c, input logic [7:0] d);
    for (int k = 0; k < 8; k++)
      c = (c[0] ^ d[k]) ? ((c >> 1) ^ `HDTX_CRC_POLY) : (c >> 1);
    return c;
  endfunction
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    rd_stb <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    addr <= a;
    rd_stb <= 1'b1;
    wr_stb <= 1'b0;
    rq.push_back(e);
    @(posedge clk_sys);
  endtask
  task automatic idle(input int n);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic push_frame(input logic [7:0] b[$], input logic crc);
    logic [15:0] c;
    c = `HDTX_CRC_INIT;
    foreach (b[i]) begin
      bq.push_back({1'b0, b[i]});
      c = crc_add(c, b[i]);
    end
    c = ~c;
    if (crc) begin
      bq.push_back({1'b0, c[7:0]});
      bq.push_back({1'b0, c[15:8]});
    end
  endtask
  task automatic send(input int n, input logic crc, input logic last);
    logic [7:0] b[$];
    // second byte all ones forces zero insertion
    for (int i = 0; i < n; i++) begin
      b.push_back((i == 1) ? 8'hff : 8'(rnd()));
      wr((i == n - 1 && last) ? 6'h04 : 6'h03, b[i]);
    end
    push_frame(b, crc && last);
    if (!last) bq.push_back(9'h100);
  endtask
  task automatic drain();
    int t;
    t = 0;
    idle(1);
    while (bq.size() != 0 && t < 30000) begin
      @(posedge clk_sys);
      t++;
    end
    cmp(16'(bq.size()), 16'h0);
    repeat (40) @(posedge clk_sys);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ****************
  // clock, watcher, watchdog
  // ****************
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= rst_n ? cyc + 1 : 0;
    rd_d_r <= rd_stb;
    if (rd_d_r) cmp(rdata, (rq.size() != 0) ? rq.pop_front() : 16'hdead);
    if (byte_vld) cmp({1'b0, byte_val}, (bq.size() != 0) ? bq.pop_front() : 16'hdead);
    if (abort_vld) cmp(9'h100, (bq.size() != 0) ? bq.pop_front() : 16'hdead);
  end
  initial begin
    #(40 * 90000);
    n_mismatch++;
    give_verdict();
  end

  // ****************
  // tests
  // ****************
  initial begin
    {rst_n, wr_stb, rd_stb, addr, wdata, pace} = '0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    wr(6'h31, 8'hff);
    foreach (RA[i]) rd(RA[i], RE[i]);
    idle(3);
    $display("test registers done");
    for (int i = 0; i < 3; i++) wr(6'(i * 16), 8'h03);
    idle(40);
    n0 = n_flag;
    idle(160);
    cmp(16'(n_flag - n0 >= 16'd19), 16'h1);
    // lanes were enabled one cycle apart, so lane 1's flags lag lane 0 by one bit and lane 2's by two
    for (int j = 0; j < 18; j++) begin
      @(negedge clk_sys);
      h0 = {h0[1:0], tx_bit[0]};
      if (j >= 2) begin
        cmp(tx_bit[1], h0[1]);
        cmp(tx_bit[2], h0[2]);
      end
    end
    @(posedge clk_sys);
    $display("test idle done");
    wr(6'h23, 8'h01);
    wr(6'h23, 8'h02);
    wr(6'h13, 8'h03);
    idle(200);
    rd(6'h26, 8'h02);
    rd(6'h16, 8'h01);
    rd(6'h06, 8'h00);
    idle(3);
    $display("test instances done");
    for (int k = 0; k < 4; k++) begin
      pace <= 2'(rnd());
      if (k == 3) wr(6'h00, 8'h01);
      send(1 + int'(rnd() % 8), k != 3, 1'b1);
      send(2, k != 3, 1'b1);
      drain();
    end
    $display("test packets done");
    wr(6'h00, 8'h07);
    wr(6'h01, 8'h06);
    idle(3);
    cmp(fifo_low, 3'h1);
    send(3, 1'b1, 1'b1);
    idle(200);
    rd(6'h06, 8'h03);
    send(3, 1'b1, 1'b1);
    drain();
    $display("test threshold done");
    pace <= 2'h3;
    wr(6'h00, 8'h03);
    send(128, 1'b1, 1'b0);
    drain();
    cmp(underrun_flag, 3'h1);
    rd(6'h05, 8'h01);
    wr(6'h05, 8'h01);
    rd(6'h05, 8'h00);
    idle(3);
    $display("test underrun done");
    pace <= 2'h0;
    wr(6'h00, 8'h0b);
    bq.push_back(9'h100);
    idle(40);
    n0 = n_flag;
    idle(100);
    cmp(n_flag, n0);
    wr(6'h00, 8'h03);
    drain();
    $display("test abort done");
    wr(6'h07, 8'h5a);
    wr(6'h08, 8'hc3);
    wr(6'h03, 8'h11);
    wr(6'h03, 8'h22);
    idle(1);
    while (cyc % RPT != 20) @(posedge clk_sys);
    wr(6'h00, 8'h33);
    push_frame('{8'h5a, 8'hc3}, 1'b1);
    drain();
    wr(6'h00, 8'h03);
    wr(6'h04, 8'h33);
    push_frame('{8'h11, 8'h22, 8'h33}, 1'b1);
    drain();
    $display("test report done");
    give_verdict();
  end
endmodule // test_hdtx_top
`default_nettype wire

/* File: hdl/hdtx_defs.svh */
`ifndef HDTX_DEFS_SVH
`define HDTX_DEFS_SVH
`define HDTX_REG_CFG 4'h0
`define HDTX_REG_UPPER 4'h1
`define HDTX_REG_LOWER 4'h2
`define HDTX_REG_DATA 4'h3
`define HDTX_REG_LAST 4'h4
`define HDTX_REG_STATUS 4'h5
`define HDTX_REG_DEPTH 4'h6
`define HDTX_REG_PERF0 4'h7
`define HDTX_REG_PERF1 4'h8
`define HDTX_CFG_EN 0
`define HDTX_CFG_CRC 1
`define HDTX_CFG_THR 2
`define HDTX_CFG_ABORT 3
`define HDTX_CFG_PERF 4
`define HDTX_CFG_FDL 5
`define HDTX_STS_UDR 0
`define HDTX_STS_LOW 1
`define HDTX_STS_FULL 2
`define HDTX_CFG_RST 8'h00
`define HDTX_UPPER_RST 8'h40
`define HDTX_LOWER_RST 8'h10
`define HDTX_PERF_RST 8'h00
`define HDTX_FIFO_DEPTH 8'h80
`define HDTX_FLAG 8'h7e
`define HDTX_ABORT 8'hfe
`define HDTX_CRC_POLY 16'h8408
`define HDTX_CRC_INIT 16'hffff
`define HDTX_STUFF_ONES 3'h5
`define HDTX_CLK_HZ 25000000
`define HDTX_RPT_MS 1000
`define HDTX_RPT_CYC (`HDTX_RPT_MS * (`HDTX_CLK_HZ / 1000))
`endif

/* File: hdl/hdtx_pkg.sv */
`default_nettype none
package hdtx_pkg;
  typedef enum logic [2:0] {ST_FLAG, ST_DATA, ST_CRC, ST_RPT, ST_ABORT} hdtx_state_t;
  typedef struct packed {
    logic wr;
    logic [3:0] idx;
    logic [7:0] data;
  } hdtx_req_t;
endpackage
`default_nettype wire

/* File: hdl/hdtx_top.sv */
`include "hdtx_defs.svh"
`default_nettype none

module hdtx_chan import hdtx_pkg::*; #(
  parameter bit IS_FIRST = 1'b0
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire hdtx_req_t req,
  input wire logic bit_en,
  input wire logic rpt_tick,
  output logic [7:0] rd_val,
  output logic tx_bit,
  output logic underrun_flag,
  output logic fifo_low
);
  // ****************************************
  // crc-ccitt, lsb first
  // ****************************************
  function automatic logic [15:0] crc_bit(input logic [15:0] c, input logic b);
    crc_bit = (c >> 1) ^ (((c[0] ^ b)) ? `HDTX_CRC_POLY : 16'h0000);
  endfunction

  logic [8:0] mem [0:127];
  logic [7:0] cfg_r, cfg_nxt, upper_r, upper_nxt, lower_r, lower_nxt;
  logic [7:0] perf0_r, perf0_nxt, perf1_r, perf1_nxt;
  logic [6:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [7:0] cnt_r, cnt_nxt, pkt_r, pkt_nxt, sh_r, sh_nxt, hold_r, hold_nxt;
  logic [15:0] crc_r, crc_nxt;
  logic [2:0] bcnt_r, bcnt_nxt, ones_r, ones_nxt;
  hdtx_state_t st_r, st_nxt;
  logic eom_r, eom_nxt, idx_r, idx_nxt, burst_r, burst_nxt;
  logic pend_r, pend_nxt, tx_r, tx_nxt, udr_r, udr_nxt, low_r, low_nxt;
  logic push, pop, full, en, stuff_now, bnd, start, rpt_go, stuffed;

  assign en = cfg_r[`HDTX_CFG_EN];
  assign full = (cnt_r == `HDTX_FIFO_DEPTH);
  assign push = req.wr && !full &&
    (req.idx == `HDTX_REG_DATA || req.idx == `HDTX_REG_LAST);
  assign stuff_now = (ones_r == `HDTX_STUFF_ONES);
  assign bnd = en && bit_en && !stuff_now && (bcnt_r == 3'h7);
  assign stuffed = (st_r == ST_DATA) || (st_r == ST_CRC) || (st_r == ST_RPT);
  assign rpt_go = IS_FIRST && pend_r && cfg_r[`HDTX_CFG_PERF] && cfg_r[`HDTX_CFG_FDL];
  // threshold mode runs off the burst latch, default mode off whole packets or a full fifo
  assign start = cfg_r[`HDTX_CFG_THR] ? (burst_r || cnt_r >= upper_r)
    : (pkt_r != 8'h00 || full);

  // ****************************************
  // software registers
  // ****************************************
  always_comb begin
    cfg_nxt = cfg_r;
    upper_nxt = upper_r;
    lower_nxt = lower_r;
    perf0_nxt = perf0_r;
    perf1_nxt = perf1_r;
    if (req.wr) begin
      case (req.idx)
        `HDTX_REG_CFG: cfg_nxt = req.data;
        `HDTX_REG_UPPER: upper_nxt = req.data;
        `HDTX_REG_LOWER: lower_nxt = req.data;
        `HDTX_REG_PERF0: perf0_nxt = req.data;
        `HDTX_REG_PERF1: perf1_nxt = req.data;
        default: ;
      endcase
    end
    low_nxt = cfg_r[`HDTX_CFG_THR] && (cnt_r < lower_r);
    case (req.idx)
      `HDTX_REG_CFG: rd_val = cfg_r;
      `HDTX_REG_UPPER: rd_val = upper_r;
      `HDTX_REG_LOWER: rd_val = lower_r;
      `HDTX_REG_STATUS: rd_val = {5'h00, full, low_r, udr_r};
      `HDTX_REG_DEPTH: rd_val = cnt_r;
      `HDTX_REG_PERF0: rd_val = perf0_r;
      `HDTX_REG_PERF1: rd_val = perf1_r;
      default: rd_val = 8'h00;
    endcase
  end

  // ****************************************
  // bit engine and frame sequencing
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    bcnt_nxt = bcnt_r;
    ones_nxt = ones_r;
    crc_nxt = crc_r;
    eom_nxt = eom_r;
    idx_nxt = idx_r;
    tx_nxt = tx_r;
    pop = 1'b0;
    udr_nxt = udr_r;
    // clear sits ahead of the event logic so a fresh underrun wins
    if (req.wr && req.idx == `HDTX_REG_STATUS && req.data[`HDTX_STS_UDR])
      udr_nxt = 1'b0;
    pend_nxt = pend_r;
    burst_nxt = burst_r;
    if (cnt_r >= upper_r) burst_nxt = 1'b1;
    if (!en) begin
      // disabled line idles at mark, restarts on a flag boundary
      st_nxt = ST_FLAG;
      sh_nxt = `HDTX_FLAG;
      bcnt_nxt = 3'h0;
      ones_nxt = 3'h0;
      tx_nxt = 1'b1;
    end else if (bit_en && stuff_now) begin
      tx_nxt = 1'b0;
      ones_nxt = 3'h0;
    end else if (bit_en) begin
      tx_nxt = sh_r[0];
      sh_nxt = {1'b0, sh_r[7:1]};
      bcnt_nxt = bcnt_r + 3'h1;
      ones_nxt = (stuffed && sh_r[0]) ? ones_r + 3'h1 : 3'h0;
      if (st_r == ST_DATA || st_r == ST_RPT) crc_nxt = crc_bit(crc_r, sh_r[0]);
    end
    if (bnd) begin
      if (cfg_r[`HDTX_CFG_ABORT]) begin
        st_nxt = ST_ABORT;
        sh_nxt = `HDTX_ABORT;
      end else begin
        case (st_r)
          ST_DATA: begin
            if (eom_r) begin
              if (cnt_r < upper_r && hold_r == 8'h00) burst_nxt = 1'b0;
              st_nxt = cfg_r[`HDTX_CFG_CRC] ? ST_CRC : ST_FLAG;
              sh_nxt = cfg_r[`HDTX_CFG_CRC] ? ~crc_nxt[7:0] : `HDTX_FLAG;
              idx_nxt = 1'b0;
            end else if (cnt_r == 8'h00) begin
              st_nxt = ST_ABORT;
              sh_nxt = `HDTX_ABORT;
              udr_nxt = 1'b1;
            end else begin
              pop = 1'b1;
              sh_nxt = mem[rp_r][7:0];
              eom_nxt = mem[rp_r][8];
            end
          end
          ST_RPT: begin
            if (!idx_r) begin
              idx_nxt = 1'b1;
              sh_nxt = perf1_r;
            end else begin
              st_nxt = ST_CRC;
              idx_nxt = 1'b0;
              sh_nxt = ~crc_nxt[7:0];
            end
          end
          ST_CRC: begin
            if (!idx_r) begin
              idx_nxt = 1'b1;
              sh_nxt = ~crc_r[15:8];
            end else begin
              st_nxt = ST_FLAG;
              sh_nxt = `HDTX_FLAG;
            end
          end
          default: begin
            // report chosen only between frames, so it never cuts a packet
            if (rpt_go) begin
              st_nxt = ST_RPT;
              sh_nxt = perf0_r;
              idx_nxt = 1'b0;
              pend_nxt = 1'b0;
              crc_nxt = `HDTX_CRC_INIT;
            end else if (start && cnt_r != 8'h00) begin
              st_nxt = ST_DATA;
              pop = 1'b1;
              sh_nxt = mem[rp_r][7:0];
              eom_nxt = mem[rp_r][8];
              crc_nxt = `HDTX_CRC_INIT;
            end else begin
              st_nxt = ST_FLAG;
              sh_nxt = `HDTX_FLAG;
            end
          end
        endcase
      end
    end
    if (rpt_tick) pend_nxt = 1'b1;
    wp_nxt = push ? wp_r + 7'h01 : wp_r;
    rp_nxt = pop ? rp_r + 7'h01 : rp_r;
    cnt_nxt = cnt_r + {7'h00, push} - {7'h00, pop};
    pkt_nxt = pkt_r + {7'h00, push && req.idx == `HDTX_REG_LAST}
      - {7'h00, pop && mem[rp_r][8]};
    // bytes still queued up to the last one pushed at or above the upper level
    hold_nxt = (pop && hold_r != 8'h00) ? hold_r - 8'h01 : hold_r;
    if (push && cnt_nxt >= upper_r) hold_nxt = cnt_nxt;
  end

  always_ff @(posedge clk_sys) begin
    if (push) mem[wp_r] <= {req.idx == `HDTX_REG_LAST, req.data};
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= `HDTX_CFG_RST;
      upper_r <= `HDTX_UPPER_RST;
      lower_r <= `HDTX_LOWER_RST;
      perf0_r <= `HDTX_PERF_RST;
      perf1_r <= `HDTX_PERF_RST;
      wp_r <= 7'h00;
      rp_r <= 7'h00;
      cnt_r <= 8'h00;
      pkt_r <= 8'h00;
      hold_r <= 8'h00;
      sh_r <= `HDTX_FLAG;
      crc_r <= `HDTX_CRC_INIT;
      bcnt_r <= 3'h0;
      ones_r <= 3'h0;
      st_r <= ST_FLAG;
      eom_r <= 1'b0;
      idx_r <= 1'b0;
      burst_r <= 1'b0;
      pend_r <= 1'b0;
      tx_r <= 1'b1;
      udr_r <= 1'b0;
      low_r <= 1'b0;
    end else begin
      cfg_r <= cfg_nxt;
      upper_r <= upper_nxt;
      lower_r <= lower_nxt;
      perf0_r <= perf0_nxt;
      perf1_r <= perf1_nxt;
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      pkt_r <= pkt_nxt;
      hold_r <= hold_nxt;
      sh_r <= sh_nxt;
      crc_r <= crc_nxt;
      bcnt_r <= bcnt_nxt;
      ones_r <= ones_nxt;
      st_r <= st_nxt;
      eom_r <= eom_nxt;
      idx_r <= idx_nxt;
      burst_r <= burst_nxt;
      pend_r <= pend_nxt;
      tx_r <= tx_nxt;
      udr_r <= udr_nxt;
      low_r <= low_nxt;
    end
  end

  assign tx_bit = tx_r;
  assign underrun_flag = udr_r;
  assign fifo_low = low_r;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_stuff;
    en && bit_en && stuff_now |=> !tx_bit ##0 ones_r == 3'h0;
  endproperty
  a_stuff: assert property (p_stuff) else $error("no zero after five ones");
  property p_underrun;
    bnd && st_r == ST_DATA && !eom_r && cnt_r == 8'h00 && !cfg_r[`HDTX_CFG_ABORT]
      |=> st_r == ST_ABORT && underrun_flag;
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun not aborted");
  property p_udr_sticky;
    underrun_flag && !(req.wr && req.idx == `HDTX_REG_STATUS) |=> underrun_flag;
  endproperty
  a_udr_sticky: assert property (p_udr_sticky) else $error("underrun flag lost");
  property p_abort;
    bnd && cfg_r[`HDTX_CFG_ABORT] |=> st_r == ST_ABORT && sh_r == `HDTX_ABORT;
  endproperty
  a_abort: assert property (p_abort) else $error("abort bit ignored");
  property p_crc_end;
    bnd && st_r == ST_DATA && eom_r && !cfg_r[`HDTX_CFG_ABORT]
      |=> st_r == ($past(cfg_r[`HDTX_CFG_CRC]) ? ST_CRC : ST_FLAG);
  endproperty
  a_crc_end: assert property (p_crc_end) else $error("wrong frame ending");
  property p_no_preempt;
    st_r == ST_DATA |=> st_r != ST_RPT;
  endproperty
  a_no_preempt: assert property (p_no_preempt) else $error("report cut a packet");
  property p_depth;
    cnt_r <= `HDTX_FIFO_DEPTH;
  endproperty
  a_depth: assert property (p_depth) else $error("fifo depth above 128");
  property p_full_start;
    bnd && st_r == ST_FLAG && full && !cfg_r[`HDTX_CFG_THR] &&
      !cfg_r[`HDTX_CFG_ABORT] && !rpt_go |=> st_r == ST_DATA;
  endproperty
  a_full_start: assert property (p_full_start) else $error("full fifo not sent");
  property p_thr_wait;
    bnd && st_r == ST_FLAG && cfg_r[`HDTX_CFG_THR] && !burst_r && cnt_r < upper_r
      |=> st_r != ST_DATA;
  endproperty
  a_thr_wait: assert property (p_thr_wait) else $error("sent below threshold");
  property p_idle;
    bnd && st_r == ST_FLAG && !start && !rpt_go && !cfg_r[`HDTX_CFG_ABORT]
      |=> st_r == ST_FLAG && sh_r == `HDTX_FLAG;
  endproperty
  a_idle: assert property (p_idle) else $error("idle without flag");
  c_udr: cover property (bnd && st_r == ST_DATA && !eom_r && cnt_r == 8'h00);
  c_rpt: cover property (st_r == ST_RPT ##1 st_r == ST_CRC);
  c_crc: cover property (st_r == ST_CRC ##1 st_r == ST_FLAG);
endmodule // hdtx_chan

module hdtx_top import hdtx_pkg::*; #(
  parameter int unsigned RPT_CYC = `HDTX_RPT_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [7:0] rdata,
  input wire logic [2:0] bit_en,
  output logic [2:0] tx_bit,
  output logic [2:0] underrun_flag,
  output logic [2:0] fifo_low
);
  logic [7:0] rd_val [0:2];
  logic [7:0] rdata_r, rdata_nxt;
  logic [24:0] tick_r, tick_nxt;
  logic tick_p_r, tick_p_nxt;

  // ****************************************
  // one-second report tick
  // ****************************************
  always_comb begin
    tick_p_nxt = (tick_r == 25'(RPT_CYC - 1));
    tick_nxt = tick_p_nxt ? 25'h0 : tick_r + 25'h1;
    rdata_nxt = (rd_stb && addr[5:4] != 2'h3) ? rd_val[addr[5:4]] : 8'h00;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tick_r <= 25'h0;
      tick_p_r <= 1'b0;
      rdata_r <= 8'h00;
    end else begin
      tick_r <= tick_nxt;
      tick_p_r <= tick_p_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign rdata = rdata_r;

  for (genvar i = 0; i < 3; i++) begin : g_ch
    hdtx_chan #(.IS_FIRST(i == 0)) u_ch (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .req('{wr: wr_stb && addr[5:4] == 2'(i), idx: addr[3:0], data: wdata}),
      .bit_en(bit_en[i]),
      .rpt_tick(tick_p_r),
      .rd_val(rd_val[i]),
      .tx_bit(tx_bit[i]),
      .underrun_flag(underrun_flag[i]),
      .fifo_low(fifo_low[i])
    );
  end
endmodule // hdtx_top
`default_nettype wire
